// *** hw/spm_pkg.sv ***
// Shared constants for the serial flash power mode controller.
package spm_pkg;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] SPM_CMD_SLEEP   = 8'hb9;
  localparam logic [7:0] SPM_CMD_RELEASE = 8'hab;
  localparam int         SPM_BUSY_BIT    = 0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SPM_MCLK_PERIOD_NS        = 8;
  localparam int SPM_SLEEP_ENTRY_DELAY_NS  = 3000;
  localparam int SPM_SLEEP_RELEASE_DELAY_NS = 3000;
  localparam int SPM_ENTRY_CYC =
    (SPM_SLEEP_ENTRY_DELAY_NS + SPM_MCLK_PERIOD_NS - 1) / SPM_MCLK_PERIOD_NS;
  localparam int SPM_RELEASE_CYC =
    (SPM_SLEEP_RELEASE_DELAY_NS + SPM_MCLK_PERIOD_NS - 1) / SPM_MCLK_PERIOD_NS;
  localparam int SPM_CNT_W = 10;
  localparam logic [SPM_CNT_W-1:0] SPM_ENTRY_LOAD   = SPM_CNT_W'(SPM_ENTRY_CYC - 1);
  localparam logic [SPM_CNT_W-1:0] SPM_RELEASE_LOAD = SPM_CNT_W'(SPM_RELEASE_CYC - 1);

  // ****************************************************************
  // Reset values and states
  // ****************************************************************
  localparam logic [7:0] SPM_CMD_RST = 8'h00;
  localparam logic [2:0] SPM_BIT_RST = 3'h0;
  localparam logic [2:0] SPM_BIT_LAST = 3'h7;

  typedef enum logic [2:0] {
    SPM_ACTIVE,
    SPM_STANDBY,
    SPM_SLEEP_WAIT,
    SPM_DEEP,
    SPM_RELEASE_WAIT
  } spm_state_e;

endpackage

// *** hw/spm_power_ctrl.sv ***
// Power mode controller: active, interface standby and deep sleep for a serial flash.
`timescale 1ns/1ns
module spm_power_ctrl
  import spm_pkg::*;
(
  input  wire logic       mclk,              // System clock, 125 MHz.
  input  wire logic       nrst,              // Asynchronous reset, active low.
  input  wire logic       sck,               // Serial clock from the host.
  input  wire logic       cs_n,              // Chip select pin, active low.
  input  wire logic       si,                // Serial data in.
  input  wire logic [7:0] volatile_status_one, // Status byte, same clock as mclk.
  output logic            active_mode,       // Device in active power state.
  output logic            standby_mode,      // Device in interface standby.
  output logic            deep_sleep_state,  // Device in deep sleep.
  output logic            in_transition      // Entry or release delay running.
);

  // ****************************************************************
  // Serial clock domain: command byte capture
  // ****************************************************************
  // The bit counter is cleared by chip select itself, since the host's
  // clock stands still between frames and cannot end a frame.
  logic       frame_rst;
  logic [2:0] bit_reg;
  logic [2:0] bit_next;
  logic [6:0] shift_reg;
  logic [6:0] shift_next;
  logic       first_reg;
  logic       first_next;
  logic [7:0] cmd_reg;
  logic [7:0] cmd_next;
  logic       tog_reg;
  logic       tog_next;

  assign frame_rst = cs_n | ~nrst;

  always_comb begin
    bit_next   = bit_reg + 3'h1;
    shift_next = {shift_reg[5:0], si};
    first_next = first_reg;
    cmd_next   = cmd_reg;
    tog_next   = tog_reg;
    if (bit_reg == SPM_BIT_LAST) begin
      first_next = 1'b0;
      if (first_reg) begin
        cmd_next = {shift_reg, si};
        tog_next = ~tog_reg;
      end
    end
  end

  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      bit_reg   <= SPM_BIT_RST;
      shift_reg <= 7'h00;
      first_reg <= 1'b1;
    end else begin
      bit_reg   <= bit_next;
      shift_reg <= shift_next;
      first_reg <= first_next;
    end
  end

  // Only the opcode byte of a frame is passed on; it stays stable
  // until the next frame's eighth clock, long after the toggle settles.
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      cmd_reg <= SPM_CMD_RST;
      tog_reg <= 1'b0;
    end else begin
      cmd_reg <= cmd_next;
      tog_reg <= tog_next;
    end
  end

  // ****************************************************************
  // Crossing into the system clock domain
  // ****************************************************************
  logic cs_meta_reg;
  logic cs_sync_reg;
  logic cs_prev_reg;
  logic tg_meta_reg;
  logic tg_s1_reg;
  logic tg_s2_reg;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
      tg_meta_reg <= 1'b0;
      tg_s1_reg   <= 1'b0;
      tg_s2_reg   <= 1'b0;
    end else begin
      cs_meta_reg <= cs_n;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
      tg_meta_reg <= tog_reg;
      tg_s1_reg   <= tg_meta_reg;
      tg_s2_reg   <= tg_s1_reg;
    end
  end

  logic cs_low;
  logic cs_rise;
  logic cmd_evt;
  logic busy;
  logic sleep_cmd;
  logic rel_cmd;

  assign cs_low    = ~cs_sync_reg;
  assign cs_rise   = cs_sync_reg & ~cs_prev_reg;
  assign cmd_evt   = tg_s1_reg ^ tg_s2_reg;
  assign busy      = volatile_status_one[SPM_BUSY_BIT];
  assign sleep_cmd = cmd_evt && (cmd_reg == SPM_CMD_SLEEP);
  assign rel_cmd   = cmd_evt && (cmd_reg == SPM_CMD_RELEASE);

  // ****************************************************************
  // Power state machine
  // ****************************************************************
  spm_state_e           state_reg;
  spm_state_e           state_next;
  logic [SPM_CNT_W-1:0] cnt_reg;
  logic [SPM_CNT_W-1:0] cnt_next;
  logic                 psleep_reg;
  logic                 psleep_next;
  logic                 prel_reg;
  logic                 prel_next;
  logic                 act_reg;
  logic                 act_next;
  logic                 stb_reg;
  logic                 stb_next;
  logic                 deep_reg;
  logic                 deep_next;
  logic                 trn_reg;
  logic                 trn_next;
  logic                 want_sleep;
  logic                 want_rel;

  always_comb begin
    // A command seen in the same cycle as chip select rising still counts.
    want_sleep  = psleep_reg | (sleep_cmd & ~busy);
    want_rel    = prel_reg | rel_cmd;
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    psleep_next = psleep_reg;
    prel_next   = prel_reg;
    case (state_reg)
      SPM_ACTIVE, SPM_STANDBY: begin
        psleep_next = want_sleep;
        if (cs_low) begin
          state_next = SPM_ACTIVE;
        end else if (cs_rise && want_sleep) begin
          state_next  = SPM_SLEEP_WAIT;
          cnt_next    = SPM_ENTRY_LOAD;
          psleep_next = 1'b0;
        end else if (state_reg == SPM_ACTIVE && !busy && !want_sleep) begin
          state_next = SPM_STANDBY;
        end
      end
      SPM_SLEEP_WAIT: begin
        cnt_next = cnt_reg - SPM_CNT_W'(1);
        if (cnt_reg == '0) begin
          state_next = SPM_DEEP;
          prel_next  = 1'b0;
        end
      end
      SPM_DEEP: begin
        // Only the release code is remembered; any other code leaves the
        // state untouched, as does a frame with no clock at all.
        prel_next = want_rel;
        if (cs_rise && want_rel) begin
          state_next = SPM_RELEASE_WAIT;
          cnt_next   = SPM_RELEASE_LOAD;
          prel_next  = 1'b0;
        end
      end
      SPM_RELEASE_WAIT: begin
        // Chip select toggling here is ignored; the host keeps the clock
        // still with it, so no stray frame is decoded as a command.
        cnt_next = cnt_reg - SPM_CNT_W'(1);
        if (cnt_reg == '0) begin
          state_next = SPM_STANDBY;
        end
      end
      default: begin
        state_next = SPM_STANDBY;
      end
    endcase
    act_next  = (state_next == SPM_ACTIVE) || (state_next == SPM_SLEEP_WAIT);
    stb_next  = (state_next == SPM_STANDBY);
    deep_next = (state_next == SPM_DEEP) || (state_next == SPM_RELEASE_WAIT);
    trn_next  = (state_next == SPM_SLEEP_WAIT) || (state_next == SPM_RELEASE_WAIT);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg  <= SPM_STANDBY;
      cnt_reg    <= '0;
      psleep_reg <= 1'b0;
      prel_reg   <= 1'b0;
      act_reg    <= 1'b0;
      stb_reg    <= 1'b1;
      deep_reg   <= 1'b0;
      trn_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      psleep_reg <= psleep_next;
      prel_reg   <= prel_next;
      act_reg    <= act_next;
      stb_reg    <= stb_next;
      deep_reg   <= deep_next;
      trn_reg    <= trn_next;
    end
  end

  assign active_mode      = act_reg;
  assign standby_mode     = stb_reg;
  assign deep_sleep_state = deep_reg;
  assign in_transition    = trn_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  localparam int ENTRY_CYC_I   = SPM_ENTRY_CYC;
  localparam int RELEASE_CYC_I = SPM_RELEASE_CYC;

  // ****************************************************************
  // Assertion helper: dwell time in the delay states
  // ****************************************************************
  // Counted apart from cnt_reg, so that the delay checks do not merely
  // restate the down-counter that they guard.
  logic [SPM_CNT_W-1:0] dwell_reg;
  logic [SPM_CNT_W-1:0] dwell_next;

  always_comb begin
    dwell_next = '0;
    if ((state_reg == SPM_SLEEP_WAIT || state_reg == SPM_RELEASE_WAIT)
        && state_next == state_reg) begin
      dwell_next = dwell_reg + SPM_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dwell_reg <= '0;
    end else begin
      dwell_reg <= dwell_next;
    end
  end

  select_active_a: assert property (@(posedge mclk) disable iff (!nrst)
    cs_low && (state_reg == SPM_ACTIVE || state_reg == SPM_STANDBY)
      |=> state_reg == SPM_ACTIVE && active_mode)
    else $error("chip select low did not give the active state");

  busy_holds_a: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == SPM_ACTIVE && busy |=> state_reg != SPM_STANDBY)
    else $error("standby entered while an operation was busy");

  idle_standby_a: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == SPM_ACTIVE && !cs_low && !busy && !want_sleep
      |=> state_reg == SPM_STANDBY ##1 standby_mode)
    else $error("idle device did not drop to standby");

  entry_delay_a: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == SPM_SLEEP_WAIT
      |=> (($past(dwell_reg) == ENTRY_CYC_I - 1) ? (state_reg == SPM_DEEP)
                                                 : (state_reg == SPM_SLEEP_WAIT)))
    else $error("deep sleep entry delay wrong");

  busy_refuse_a: assert property (@(posedge mclk) disable iff (!nrst)
    (state_reg == SPM_ACTIVE || state_reg == SPM_STANDBY) && !psleep_reg && sleep_cmd
      && busy && !cs_rise
      |=> !psleep_reg)
    else $error("sleep command taken while busy");

  deep_ignore_a: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == SPM_DEEP && !prel_reg && !rel_cmd |=> state_reg == SPM_DEEP)
    else $error("deep sleep left without release command");

  release_delay_a: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == SPM_RELEASE_WAIT
      |=> (($past(dwell_reg) == RELEASE_CYC_I - 1) ? (state_reg == SPM_STANDBY)
                                                   : (state_reg == SPM_RELEASE_WAIT)))
    else $error("release delay wrong");

  deep_entry_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(state_reg == SPM_DEEP) |-> $past(state_reg) == SPM_SLEEP_WAIT)
    else $error("deep sleep entered without the entry delay");

  deep_flag_a: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == SPM_DEEP |=> deep_sleep_state && !active_mode)
    else $error("deep sleep flag inconsistent with state");

endmodule

// *** verification/spm_host_model.sv ***
// SPI host model that sends one opcode per frame on the serial link.
`timescale 1ns/1ns
module spm_host_model (
  output logic sck,  // Serial clock, still outside frames.
  output logic cs_n, // Chip select, active low.
  output logic si    // Serial data, MSB first.
);
  localparam int HALF_NS = 24;

  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // Sends the top nbits of code; zero bits selects the device with no clock.
  task automatic frame(input logic [7:0] code, input int nbits);
    int i;
    #5 cs_n = 1'b0;
    #HALF_NS;
    for (i = 0; i < nbits; i++) begin
      si = code[7 - i];
      #HALF_NS sck = 1'b1;
      #HALF_NS sck = 1'b0;
    end
    #HALF_NS cs_n = 1'b1;
    // A released data line must not keep showing its last bit.
    si = ~si;
  endtask
endmodule

// *** verification/spm_power_ctrl_tb.sv ***
// Self-checking bench for the power mode controller.
`timescale 1ns/1ns
module spm_power_ctrl_tb;
  import spm_pkg::*;
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end

  logic       mclk;
  logic       nrst;
  logic       sck;
  logic       cs_n;
  logic       si;
  logic [7:0] status;
  logic       active_mode;
  logic       standby_mode;
  logic       deep_sleep_state;
  logic       in_transition;
  int         errors;
  int         compares;
  int         model_mode;

  spm_host_model host (.sck(sck), .cs_n(cs_n), .si(si));

  spm_power_ctrl dut (
    .mclk(mclk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si),
    .volatile_status_one(status), .active_mode(active_mode),
    .standby_mode(standby_mode), .deep_sleep_state(deep_sleep_state),
    .in_transition(in_transition)
  );

  always #4 mclk = ~mclk;

  // ****
  // Model and checks
  // ****
  task automatic results();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Mode 0 is active, 1 standby, 2 deep sleep.
  task automatic expect_state(input int m, input logic tr);
    logic [3:0] exp;
    exp = {m == 0, m == 1, m == 2, tr};
    `CHK("modes", exp, {active_mode, standby_mode, deep_sleep_state, in_transition})
  endtask

  task automatic wait_delay(input int n);
    int cnt;
    cnt = 0;
    while (in_transition === 1'b1 && cnt < n + 50) begin
      @(negedge mclk);
      cnt++;
    end
    `CHK("delay", 1'b1, cnt >= n - 10 && cnt <= n)
    if (cnt >= n + 50)
      results();
  endtask

  task automatic send(input logic [7:0] code, input int nbits);
    fork
      host.frame(code, nbits);
      begin
        repeat (20) @(negedge mclk);
        if (model_mode != 2)
          expect_state(0, 1'b0);
        else
          expect_state(2, 1'b0);
      end
    join
    repeat (10) @(negedge mclk);
    if (model_mode == 2 && nbits == 8 && code == SPM_CMD_RELEASE) begin
      expect_state(2, 1'b1);
      wait_delay(SPM_RELEASE_CYC);
      model_mode = 1;
    end else if (model_mode != 2 && nbits == 8 && code == SPM_CMD_SLEEP
                 && status[SPM_BUSY_BIT] == 1'b0) begin
      expect_state(0, 1'b1);
      wait_delay(SPM_ENTRY_CYC);
      model_mode = 2;
    end else if (model_mode != 2) begin
      model_mode = status[SPM_BUSY_BIT] ? 0 : 1;
    end
    expect_state(model_mode, 1'b0);
  endtask

  task automatic set_busy(input logic b);
    @(negedge mclk);
    status = (8'($urandom) & 8'hfe) | {7'h00, b};
  endtask

  task automatic drop_busy();
    set_busy(1'b0);
    repeat (10) @(negedge mclk);
    if (model_mode == 0)
      model_mode = 1;
    expect_state(model_mode, 1'b0);
  endtask

  function automatic logic [7:0] other_code();
    logic [7:0] c;
    c = 8'($urandom);
    if (c == SPM_CMD_SLEEP || c == SPM_CMD_RELEASE)
      c = 8'h03;
    return c;
  endfunction

  // ****
  // Main sequence
  // ****
  initial begin
    mclk       = 1'b0;
    nrst       = 1'b0;
    status     = 8'h00;
    errors     = 0;
    compares   = 0;
    model_mode = 1;
    void'($urandom(31));
    repeat (8) @(negedge mclk);
    expect_state(1, 1'b0);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    expect_state(1, 1'b0);
    $display("test reset done");
    set_busy(1'b0);
    send(other_code(), 8);
    set_busy(1'b1);
    send(other_code(), 8);
    drop_busy();
    $display("test busy hold done");
    set_busy(1'b1);
    send(SPM_CMD_SLEEP, 8);
    drop_busy();
    send(SPM_CMD_SLEEP, 7);
    $display("test sleep refused done");
    send(SPM_CMD_SLEEP, 8);
    $display("test sleep entry done");
    send(8'h00, 0);
    repeat (4) send(other_code(), 8);
    send(SPM_CMD_SLEEP, 8);
    send(SPM_CMD_RELEASE, 7);
    $display("test deep ignore done");
    send(SPM_CMD_RELEASE, 8);
    send(SPM_CMD_SLEEP, 8);
    send(SPM_CMD_RELEASE, 8);
    $display("test release done");
    results();
  end
endmodule
